// *** verilog/amad_top.sv ***
/*
 * Decode, access checks and storage of the converter register window:
 * registers, command table, result table with three aliases, ports.
 * Assumes the master splits long words into two word cycles
 * and drives requests from logic on the same clock.
 */
`default_nettype none
`include "amad_consts.svh"

// Overview of operation
// - claim a 512-byte window of 256 words, answer only inside it
// - address is 15-bit base joined with 9-bit offset; decode low nine bits
// - base address top bit comes from the module map bit
// - offsets 0x000 to 0x010 are the nine word registers
// - configuration, test and interrupt registers are always supervisor only
// - space assign bit makes other space supervisor only or open to all
// - non-supervisor read of always supervisor-only space returns all zeros
// - user read of assignable space held by supervisor returns all ones
// - user writes to protected space change nothing
// - master without user mode: every access is supervisor, assign bit ignored
// - command table is 40 words at 0x030 to 0x07E, ten bits each
// - result table has 40 ten-bit entries shared by all three aliases
// - result reads: right unsigned, left signed, left unsigned per alias
// - listed reserved ranges map to no register or entry
// - spare channel pins read through the two port data bytes, written only through the first (upper) byte
// - direction register picks input or output per first port pin
// - only first port drives, open drain pull-down only
// - all 16 channel pins usable as digital port pins
// - status register shows both queue states and conversion in progress
// - control registers: hardware config, queue one, queue two
// - act as bus slave and terminate every claimed cycle
// - accept byte, word and long word reads and writes
// - first port direction bits sit in upper byte of direction register
module amad_top
   import amad_pkg::*;
#(
   parameter logic [13:0] BASE_LOW  = 14'h3FFF,   // base address below the map bit
   parameter int          DEPTH     = `AMAD_TABLE_DEPTH // table entries
)
(
   input  wire logic                      clock,          // 50 MHz clock
   input  wire logic                      rst_b,          // sync reset, active low
   input  wire logic                      bus_start,      // one-cycle access request
   input  wire logic [`AMAD_ADDR_W-1:0]   bus_addr,       // byte address
   input  wire logic                      bus_read,       // 1 read, 0 write
   input  wire logic                      bus_byte,       // 1 byte, 0 word
   input  wire logic                      bus_fc2,        // function code bit 2, 1 supervisor
   input  wire logic                      user_capable,   // master has user mode
   input  wire logic [`AMAD_DATA_W-1:0]   bus_wdata,      // write data, even byte high
   output logic [`AMAD_DATA_W-1:0]        bus_rdata,      // read data
   output logic                           bus_ack,        // cycle termination pulse
   input  wire logic                      res_we,         // sequencer result strobe
   input  wire logic [`AMAD_IDX_W-1:0]    res_idx,        // result entry index
   input  wire logic [`AMAD_ENTRY_BITS-1:0] res_val,      // conversion value
   input  wire logic [`AMAD_IDX_W-1:0]    ccw_idx,        // sequencer command index
   output logic [`AMAD_ENTRY_BITS-1:0]    ccw_word,       // command word, one cycle late
   input  wire amad_word_t                status_in,      // queue states and current command
   output amad_word_t                     hw_cfg,         // hardware config control
   output amad_word_t                     q1_ctrl,        // queue one control
   output amad_word_t                     q2_ctrl,        // queue two control
   output amad_word_t                     int_setup,      // interrupt setup
   output amad_word_t                     test_cfg,       // factory test
   input  wire logic [7:0]                port_a_pin_in,  // first port pin levels
   output logic [7:0]                     port_a_pin_out, // first port drive level
   output logic [7:0]                     port_a_oe_b,    // low while pulling pin down
   input  wire logic [7:0]                port_b_pin_in   // second port pin levels
);
   import amad_pkg::*;

   // -------------------------------------------------------------------------
   // storage
   // -------------------------------------------------------------------------
   amad_word_t                      module_config_reg;
   amad_word_t                      factory_test_reg;
   amad_word_t                      interrupt_setup_reg;
   logic [7:0]                      first_port_data_reg;
   logic [7:0]                      port_direction_reg;
   amad_word_t                      hardware_config_ctrl_reg;
   amad_word_t                      queue_one_ctrl_reg;
   amad_word_t                      queue_two_ctrl_reg;
   logic [`AMAD_ENTRY_BITS-1:0]     command_word_table [DEPTH];
   logic [`AMAD_ENTRY_BITS-1:0]     result_table [DEPTH];
   logic [7:0]                      port_a_meta_reg;
   logic [7:0]                      port_a_sync_reg;
   logic [7:0]                      port_b_meta_reg;
   logic [7:0]                      port_b_sync_reg;
   amad_word_t                      rdata_reg;
   logic                            ack_reg;
   logic [`AMAD_ENTRY_BITS-1:0]     ccw_word_reg;
   logic [7:0]                      port_a_oe_b_reg;

   // -------------------------------------------------------------------------
   // decode
   // -------------------------------------------------------------------------
   logic [`AMAD_OFF_W-1:0]          off;
   logic [`AMAD_BASE_W-1:0]         base;
   logic                            hit;
   logic                            sup;
   logic                            global_space;
   logic                            assigned_locked;
   amad_region_e                    region;
   logic [`AMAD_OFF_W-1:0]          diff;
   logic [`AMAD_IDX_W-1:0]          idx;
   amad_word_t                      raw;
   amad_word_t                      rdata_next;
   logic                            wr_ok;
   logic [1:0]                      lane;
   amad_word_t                      port_word;
   logic [`AMAD_ENTRY_BITS-1:0]     res_sel;
   amad_word_t                      ccw_merged;

   assign off  = bus_addr[`AMAD_OFF_W-1:0];
   assign base = {module_config_reg[`AMAD_MODULE_MAP_BIT], BASE_LOW};
   assign hit  = bus_start && (bus_addr[`AMAD_ADDR_W-1:`AMAD_OFF_W] == base);

   // no user mode: always supervisor
   assign sup          = bus_fc2 || !user_capable;
   assign global_space = (off < `AMAD_OFF_GLOBAL_END);
   assign assigned_locked = !sup && module_config_reg[`AMAD_SPACE_ASSIGN_BIT];

   // byte lanes: even address uses the upper byte
   assign lane = bus_byte ? (off[0] ? 2'b01 : 2'b10) : 2'b11;

   always_comb
   begin
      region = AMAD_RG_RSVD;
      diff   = `AMAD_OFF_W'(0);
      if (off <= `AMAD_OFF_STATUS)
      begin
         region = AMAD_RG_REG;
      end
      else if (off >= `AMAD_OFF_CCW_LO && off <= `AMAD_OFF_CCW_HI)
      begin
         region = AMAD_RG_CCW;
         diff   = off - `AMAD_OFF_CCW_LO;
      end
      else if (off >= `AMAD_OFF_RRU_LO && off <= `AMAD_OFF_RRU_HI)
      begin
         region = AMAD_RG_RRU;
         diff   = off - `AMAD_OFF_RRU_LO;
      end
      else if (off >= `AMAD_OFF_RLS_LO && off <= `AMAD_OFF_RLS_HI)
      begin
         region = AMAD_RG_RLS;
         diff   = off - `AMAD_OFF_RLS_LO;
      end
      else if (off >= `AMAD_OFF_RLU_LO && off <= `AMAD_OFF_RLU_HI)
      begin
         region = AMAD_RG_RLU;
         diff   = off - `AMAD_OFF_RLU_LO;
      end
   end

   assign idx = diff[`AMAD_IDX_W:1];

   // -------------------------------------------------------------------------
   // port view
   // -------------------------------------------------------------------------
   // inputs show the pin, outputs show the latch
   always_comb
   begin
      port_word = {(port_direction_reg & first_port_data_reg) |
                   (~port_direction_reg & port_a_sync_reg),
                   port_b_sync_reg};
   end

   // -------------------------------------------------------------------------
   // read mux
   // -------------------------------------------------------------------------
   assign res_sel = result_table[idx];

   always_comb
   begin
      raw = `AMAD_READ_RESERVED;
      case (region)
         AMAD_RG_REG:
         begin
            case (off & ~`AMAD_OFF_W'(1))
               `AMAD_OFF_MODCFG:   raw = module_config_reg;
               `AMAD_OFF_TEST:     raw = factory_test_reg;
               `AMAD_OFF_INTSET:   raw = interrupt_setup_reg;
               `AMAD_OFF_PORTDATA: raw = port_word;
               `AMAD_OFF_PORTDIR:  raw = {port_direction_reg, `AMAD_RST_BYTE};
               `AMAD_OFF_HWCFG:    raw = hardware_config_ctrl_reg;
               `AMAD_OFF_Q1CTRL:   raw = queue_one_ctrl_reg;
               `AMAD_OFF_Q2CTRL:   raw = queue_two_ctrl_reg;
               `AMAD_OFF_STATUS:   raw = status_in;
               default:            raw = `AMAD_READ_RESERVED;
            endcase
         end
         AMAD_RG_CCW:
            raw = {`AMAD_PAD_W'(0), command_word_table[idx]};
         AMAD_RG_RRU:
            raw = {`AMAD_PAD_W'(0), res_sel};
         AMAD_RG_RLS:
            raw = {~res_sel[`AMAD_ENTRY_BITS-1], res_sel[`AMAD_ENTRY_BITS-2:0],
                   `AMAD_PAD_W'(0)};
         AMAD_RG_RLU:
            raw = {res_sel, `AMAD_PAD_W'(0)};
         default:
            raw = `AMAD_READ_RESERVED;
      endcase
   end

   always_comb
   begin
      rdata_next = raw;
      wr_ok      = hit && !bus_read && (region != AMAD_RG_RSVD);
      if (global_space && !sup)
      begin
         rdata_next = `AMAD_READ_DENIED;
         wr_ok      = 1'b0;
      end
      else if (!global_space && assigned_locked && region != AMAD_RG_RSVD)
      begin
         rdata_next = `AMAD_READ_ASSIGNED;
         wr_ok      = 1'b0;
      end
   end

   // merge a byte or word write into an existing word
   function automatic amad_word_t merge(input amad_word_t old, input amad_word_t wd,
                                        input logic [1:0] ln);
      amad_word_t r;
      r = old;
      if (ln[1])
         r[15:8] = wd[15:8];
      if (ln[0])
         r[7:0] = wd[7:0];
      return r;
   endfunction

   assign ccw_merged = merge({`AMAD_PAD_W'(0), command_word_table[idx]}, bus_wdata, lane);

   // -------------------------------------------------------------------------
   // bus answer
   // -------------------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         ack_reg   <= 1'b0;
         rdata_reg <= `AMAD_RST_WORD;
      end
      else
      begin
         ack_reg <= hit;
         if (hit && bus_read)
            rdata_reg <= rdata_next;
      end
   end

   // -------------------------------------------------------------------------
   // register writes
   // -------------------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         module_config_reg        <= `AMAD_RST_MODCFG;
         factory_test_reg         <= `AMAD_RST_WORD;
         interrupt_setup_reg      <= `AMAD_RST_WORD;
         first_port_data_reg      <= `AMAD_RST_BYTE;
         port_direction_reg       <= `AMAD_RST_BYTE;
         hardware_config_ctrl_reg <= `AMAD_RST_WORD;
         queue_one_ctrl_reg       <= `AMAD_RST_WORD;
         queue_two_ctrl_reg       <= `AMAD_RST_WORD;
      end
      else if (wr_ok && region == AMAD_RG_REG)
      begin
         case (off & ~`AMAD_OFF_W'(1))
            `AMAD_OFF_MODCFG:
               module_config_reg <= merge(module_config_reg, bus_wdata, lane);
            `AMAD_OFF_TEST:
               factory_test_reg <= merge(factory_test_reg, bus_wdata, lane);
            `AMAD_OFF_INTSET:
               interrupt_setup_reg <= merge(interrupt_setup_reg, bus_wdata, lane);
            `AMAD_OFF_PORTDATA:
            begin
               // second port is input only
               if (lane[1])
                  first_port_data_reg <= bus_wdata[15:8];
            end
            `AMAD_OFF_PORTDIR:
            begin
               if (lane[1])
                  port_direction_reg <= bus_wdata[15:8];
            end
            `AMAD_OFF_HWCFG:
               hardware_config_ctrl_reg <= merge(hardware_config_ctrl_reg, bus_wdata, lane);
            `AMAD_OFF_Q1CTRL:
               queue_one_ctrl_reg <= merge(queue_one_ctrl_reg, bus_wdata, lane);
            `AMAD_OFF_Q2CTRL:
               queue_two_ctrl_reg <= merge(queue_two_ctrl_reg, bus_wdata, lane);
            default:
            begin
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // tables
   // -------------------------------------------------------------------------
   // bus writes to result aliases are dropped
   always_ff @(posedge clock)
   begin
      if (res_we && res_idx < DEPTH[`AMAD_IDX_W-1:0])
         result_table[res_idx] <= res_val;
   end

   always_ff @(posedge clock)
   begin
      if (wr_ok && region == AMAD_RG_CCW)
         command_word_table[idx] <= ccw_merged[`AMAD_ENTRY_BITS-1:0];
   end

   always_ff @(posedge clock)
   begin
      if (!rst_b)
         ccw_word_reg <= `AMAD_ENTRY_BITS'(0);
      else if (ccw_idx < DEPTH[`AMAD_IDX_W-1:0])
         ccw_word_reg <= command_word_table[ccw_idx];
   end

   // -------------------------------------------------------------------------
   // pins
   // -------------------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         port_a_meta_reg <= `AMAD_RST_BYTE;
         port_a_sync_reg <= `AMAD_RST_BYTE;
         port_b_meta_reg <= `AMAD_RST_BYTE;
         port_b_sync_reg <= `AMAD_RST_BYTE;
      end
      else
      begin
         port_a_meta_reg <= port_a_pin_in;
         port_a_sync_reg <= port_a_meta_reg;
         port_b_meta_reg <= port_b_pin_in;
         port_b_sync_reg <= port_b_meta_reg;
      end
   end

   // pull low where output is chosen and latch is zero
   always_ff @(posedge clock)
   begin
      if (!rst_b)
         port_a_oe_b_reg <= ~`AMAD_RST_BYTE;
      else
         port_a_oe_b_reg <= ~(port_direction_reg & ~first_port_data_reg);
   end

   assign bus_ack        = ack_reg;
   assign bus_rdata      = rdata_reg;
   assign ccw_word       = ccw_word_reg;
   assign port_a_pin_out = `AMAD_RST_BYTE;
   assign port_a_oe_b    = port_a_oe_b_reg;
   assign hw_cfg         = hardware_config_ctrl_reg;
   assign q1_ctrl        = queue_one_ctrl_reg;
   assign q2_ctrl        = queue_two_ctrl_reg;
   assign int_setup      = interrupt_setup_reg;
   assign test_cfg       = factory_test_reg;

endmodule

`default_nettype wire

// *** inc/amad_consts.svh ***
/*
 * Offsets, fields, reset values and fixed read answers of the register window.
 * Assumes inclusion by bare name.
 */
`ifndef AMAD_CONSTS_SVH
`define AMAD_CONSTS_SVH

// ----------------------------------------------------------------------------
// window geometry
// ----------------------------------------------------------------------------
`define AMAD_OFF_W          9
`define AMAD_BASE_W         15
`define AMAD_ADDR_W         24
`define AMAD_DATA_W         16

// ----------------------------------------------------------------------------
// register block offsets
// ----------------------------------------------------------------------------
`define AMAD_OFF_MODCFG     9'h000
`define AMAD_OFF_TEST       9'h002
`define AMAD_OFF_INTSET     9'h004
`define AMAD_OFF_PORTDATA   9'h006
`define AMAD_OFF_PORTDIR    9'h008
`define AMAD_OFF_HWCFG      9'h00A
`define AMAD_OFF_Q1CTRL     9'h00C
`define AMAD_OFF_Q2CTRL     9'h00E
`define AMAD_OFF_STATUS     9'h010
`define AMAD_OFF_GLOBAL_END 9'h006
`define AMAD_OFF_RSVDA_LO   9'h012
`define AMAD_OFF_RSVDA_HI   9'h02E

// ----------------------------------------------------------------------------
// tables and reserved gaps
// ----------------------------------------------------------------------------
`define AMAD_OFF_CCW_LO     9'h030
`define AMAD_OFF_CCW_HI     9'h07E
`define AMAD_OFF_RSVDB_LO   9'h080
`define AMAD_OFF_RSVDB_HI   9'h0AE
`define AMAD_OFF_RRU_LO     9'h0B0
`define AMAD_OFF_RRU_HI     9'h0FE
`define AMAD_OFF_RSVDC_LO   9'h100
`define AMAD_OFF_RSVDC_HI   9'h12E
`define AMAD_OFF_RLS_LO     9'h130
`define AMAD_OFF_RLS_HI     9'h17E
`define AMAD_OFF_RSVDD_LO   9'h180
`define AMAD_OFF_RSVDD_HI   9'h1AE
`define AMAD_OFF_RLU_LO     9'h1B0
`define AMAD_OFF_RLU_HI     9'h1FE

// ----------------------------------------------------------------------------
// fields and values
// ----------------------------------------------------------------------------
`define AMAD_SPACE_ASSIGN_BIT 7
`define AMAD_MODULE_MAP_BIT   6
`define AMAD_ENTRY_BITS       10
`define AMAD_TABLE_DEPTH      40
`define AMAD_IDX_W            6
`define AMAD_PAD_W            6
`define AMAD_RST_MODCFG       16'h0080
`define AMAD_RST_WORD         16'h0000
`define AMAD_RST_BYTE         8'h00
`define AMAD_READ_DENIED      16'h0000
`define AMAD_READ_ASSIGNED    16'hFFFF
`define AMAD_READ_RESERVED    16'h0000

`endif

// *** inc/amad_pkg.sv ***
/*
 * Types of the converter address decode block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package amad_pkg;

   typedef enum logic [2:0] {
      AMAD_RG_REG,
      AMAD_RG_CCW,
      AMAD_RG_RRU,
      AMAD_RG_RLS,
      AMAD_RG_RLU,
      AMAD_RG_RSVD
   } amad_region_e;

   typedef logic [15:0] amad_word_t;

endpackage

`default_nettype wire

// *** verification/amad_properties.sv ***
/* Port checker of the register window.
   Assumes bind to amad_top; map bit clear except in the relocation step. */
`default_nettype none
module amad_checker
   import amad_pkg::*;
#(
   parameter logic [13:0] BASE_LOW = 14'h3FFF // base below map bit
)
(
   input wire logic        clock,          // clock
   input wire logic        rst_b,          // reset, active low
   input wire logic        bus_start,      // request strobe
   input wire logic [23:0] bus_addr,       // byte address
   input wire logic        bus_read,       // read
   input wire logic        bus_fc2,        // supervisor mark
   input wire logic        user_capable,   // user mode known
   input wire logic [15:0] bus_rdata,      // read data
   input wire logic        bus_ack,        // termination
   input wire amad_word_t  int_setup,      // interrupt setup
   input wire amad_word_t  test_cfg,       // factory test
   input wire logic [7:0]  port_a_pin_out, // drive level
   input wire logic [7:0]  port_a_oe_b     // drive enable
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   logic hit;
   logic user;
   assign hit = bus_start && bus_addr[23:9] == {1'b0, BASE_LOW};
   assign user = user_capable && !bus_fc2;
   // ------------------------------------------
   // sequences and properties
   // ------------------------------------------
   sequence s_global_user_read;
      hit && bus_read && user && bus_addr[8:0] < 9'h006;
   endsequence
   sequence s_reserved_read;
      hit && bus_read && bus_addr[8:0] >= 9'h012 && bus_addr[8:0] <= 9'h02E;
   endsequence
   property p_ack_on_take; hit |=> bus_ack; endproperty
   property p_ack_cause; bus_ack |-> $past(bus_start); endproperty
   property p_no_ack_out; bus_start && bus_addr[22:9] != BASE_LOW |=> !bus_ack; endproperty
   property p_global_zero; s_global_user_read |=> bus_rdata == 16'h0000; endproperty
   property p_user_wr_block; bus_start && !bus_read && user |=> $stable(int_setup) && $stable(test_cfg); endproperty
   property p_reserved_zero; s_reserved_read |=> bus_ack && bus_rdata == 16'h0000; endproperty
   property p_pull_down; port_a_pin_out == 8'h00; endproperty
   property p_oe_after_wr; !$stable(port_a_oe_b) |-> $past(bus_ack) && !$past(bus_read, 2); endproperty
   a_ack_on_take: assert property (p_ack_on_take)
      else $error("claimed access not terminated");
   a_ack_cause: assert property (p_ack_cause)
      else $error("termination without request");
   a_no_ack_out: assert property (p_no_ack_out)
      else $error("outside access terminated");
   a_global_zero: assert property (p_global_zero)
      else $error("user global read not zero");
   a_user_wr_block: assert property (p_user_wr_block)
      else $error("user write changed global");
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved read wrong");
   a_pull_down: assert property (p_pull_down)
      else $error("first port drives high");
   a_oe_after_wr: assert property (p_oe_after_wr)
      else $error("enable moved without write");
endmodule
bind amad_top amad_checker #(.BASE_LOW(BASE_LOW)) u_checker (.clock, .rst_b, .bus_start, .bus_addr, .bus_read,
   .bus_fc2, .user_capable, .bus_rdata, .bus_ack, .int_setup, .test_cfg, .port_a_pin_out, .port_a_oe_b);
`default_nettype wire

// *** verification/amad_host.sv ***
/* Host model: bus master, one access at a time.
   Assumes the bench calls access on the block clock. */
`default_nettype none
module amad_host
(
   input  wire logic        clock,        // block clock
   output var  logic        bus_start,    // request strobe
   output var  logic [23:0] bus_addr,     // byte address
   output var  logic        bus_read,     // read
   output var  logic        bus_byte,     // byte size
   output var  logic        bus_fc2,      // supervisor mark
   output var  logic        user_capable, // user mode known
   output var  logic [15:0] bus_wdata,    // write data
   input  wire logic [15:0] bus_rdata,    // read data
   input  wire logic        bus_ack       // termination
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      {bus_start, bus_read, bus_byte, bus_fc2, user_capable} = 5'b01011;
      {bus_addr, bus_wdata} = 40'h0;
   end
   // ------------------------------------------
   // mode 0 user, 1 supervisor, 2 master without user mode
   // ------------------------------------------
   task automatic access(input logic [23:0] a, input logic rd, input logic byt, input logic [1:0] mode,
                         input logic [15:0] wd, output logic [15:0] rdata, output logic acked);
      int n;
      @(posedge clock);
      bus_start <= 1'b1;
      bus_addr <= a;
      bus_read <= rd;
      bus_byte <= byt;
      bus_fc2 <= mode == 2'd1;
      user_capable <= mode != 2'd2;
      bus_wdata <= wd;
      @(posedge clock);
      bus_start <= 1'b0;
      acked = 1'b0;
      rdata = 16'h0000;
      for (n = 0; n < 3 && !acked; n++)
      begin
         @(posedge clock);
         acked = bus_ack;
         rdata = bus_rdata;
      end
      // released lines show the inverse
      bus_addr <= ~a;
      bus_wdata <= ~wd;
   endtask
endmodule
`default_nettype wire

// *** verification/test_adc_module_address_decode.sv ***
/* Bench of the register window: host on the bus, bench on the rest.
   Assumes default base and a pulled-up first port. */
`default_nettype none
module test_adc_module_address_decode;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [1:0] USR = 2'h0, SUP = 2'h1, NOU = 2'h2;
   logic        clock = 1'b0, rst_b = 1'b0, res_we = 1'b0, bus_start, bus_read, bus_byte, bus_fc2, user_capable;
   logic        bus_ack, ack;
   logic [23:0] bus_addr;
   logic [15:0] bus_wdata, bus_rdata, rd, hw_cfg, q1_ctrl, q2_ctrl, int_setup, test_cfg, status_in = 16'hA5C3;
   logic [9:0]  res_val = 10'h2A5, ccw_word;
   logic [5:0]  res_idx = 6'h27, ccw_idx = 6'h00;
   logic [7:0]  port_a_pin_out, port_a_oe_b, ext_a = 8'hFF, port_b_pin_in = 8'h3C;
   logic [8:0]  rsv [6] = '{9'h012, 9'h02E, 9'h080, 9'h0AE, 9'h100, 9'h1AE};
   wire logic [7:0] port_a_pin_in = ext_a & port_a_oe_b; // open drain onto pull-up
   int          fails = 0, checks_done = 0;
   amad_top dut (.clock, .rst_b, .bus_start, .bus_addr, .bus_read, .bus_byte, .bus_fc2, .user_capable, .bus_wdata,
      .bus_rdata, .bus_ack, .res_we, .res_idx, .res_val, .ccw_idx, .ccw_word, .status_in, .hw_cfg, .q1_ctrl,
      .q2_ctrl, .int_setup, .test_cfg, .port_a_pin_in, .port_a_pin_out, .port_a_oe_b, .port_b_pin_in);
   amad_host host (.clock, .bus_start, .bus_addr, .bus_read, .bus_byte, .bus_fc2, .user_capable, .bus_wdata,
      .bus_rdata, .bus_ack);
   // ------------------------------------------
   // helpers
   // ------------------------------------------
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic acc(input logic [8:0] off, input logic rdn, input logic [1:0] m, input logic [15:0] d);
      host.access({1'b0, 14'h3FFF, off}, rdn, 1'b0, m, d, rd, ack);
   endtask
   task automatic rdc(input string name, input logic [8:0] off, input logic [1:0] m, input logic [15:0] exp);
      acc(off, 1'b1, m, 16'h0000);
      check(name, exp, rd);
      check(name, 16'h0001, {15'h0000, ack});
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
      forever #10 clock = ~clock;
   initial
   begin
      repeat (5000) @(posedge clock);
      fails++;
      conclude();
   end
   initial
   begin
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      check("enable reset", 16'h00FF, {8'h00, port_a_oe_b});
      rdc("config reset", 9'h000, SUP, 16'h0080);
      acc(9'h00A, 1'b0, SUP, 16'h1234);
      acc(9'h00C, 1'b0, SUP, 16'h5678);
      acc(9'h00E, 1'b0, SUP, 16'h9ABC);
      acc(9'h004, 1'b0, SUP, 16'h0F0F);
      acc(9'h002, 1'b0, SUP, 16'hC35A);
      check("hw config", 16'h1234, hw_cfg);
      check("queue one", 16'h5678, q1_ctrl);
      check("queue two", 16'h9ABC, q2_ctrl);
      check("interrupt", 16'h0F0F, int_setup);
      rdc("status", 9'h010, SUP, 16'hA5C3);
      rdc("queue two read", 9'h00E, SUP, 16'h9ABC);
      $display("test registers done");
      rdc("user global", 9'h004, USR, 16'h0000);
      rdc("user test", 9'h002, USR, 16'h0000);
      rdc("user assigned", 9'h00A, USR, 16'hFFFF);
      acc(9'h00A, 1'b0, USR, 16'h0000);
      check("user write", 16'h1234, hw_cfg);
      acc(9'h002, 1'b0, USR, 16'h0000);
      check("test reg", 16'hC35A, test_cfg);
      rdc("no user mode", 9'h004, NOU, 16'h0F0F);
      rdc("no user mode assigned", 9'h00A, NOU, 16'h1234);
      acc(9'h000, 1'b0, SUP, 16'h0000);
      rdc("user open", 9'h00A, USR, 16'h1234);
      rdc("user global open", 9'h004, USR, 16'h0000);
      $display("test spaces done");
      foreach (rsv[i])
      begin
         acc(rsv[i], 1'b0, SUP, 16'hFFFF);
         rdc("reserved", rsv[i], SUP, 16'h0000);
      end
      host.access({1'b0, 14'h3FFE, 9'h00A}, 1'b1, 1'b0, SUP, 16'h0000, rd, ack);
      check("outside ack", 16'h0000, {15'h0000, ack});
      acc(9'h000, 1'b0, SUP, 16'h0040);
      host.access({1'b1, 14'h3FFF, 9'h00A}, 1'b1, 1'b0, SUP, 16'h0000, rd, ack);
      check("moved window", 16'h1234, rd);
      host.access({1'b1, 14'h3FFF, 9'h000}, 1'b0, 1'b0, SUP, 16'h0000, rd, ack);
      rdc("window back", 9'h00A, SUP, 16'h1234);
      $display("test window done");
      acc(9'h030, 1'b0, SUP, 16'hFFFF);
      acc(9'h07E, 1'b0, SUP, 16'h0155);
      rdc("first command", 9'h030, SUP, 16'h03FF);
      ccw_idx <= 6'h27;
      repeat (2) @(posedge clock);
      check("command out", 16'h0155, {6'h00, ccw_word});
      res_we <= 1'b1;
      @(posedge clock);
      res_we <= 1'b0;
      acc(9'h0FE, 1'b0, SUP, 16'h0000);
      rdc("right unsigned", 9'h0FE, SUP, {6'h00, res_val});
      rdc("left signed", 9'h17E, SUP, {~res_val[9], res_val[8:0], 6'h00});
      rdc("left unsigned", 9'h1FE, SUP, {res_val, 6'h00});
      $display("test tables done");
      acc(9'h008, 1'b0, SUP, 16'hFFFF);
      rdc("direction", 9'h008, SUP, 16'hFF00);
      host.access({1'b0, 14'h3FFF, 9'h006}, 1'b0, 1'b1, SUP, 16'h0F00, rd, ack);
      repeat (2) @(posedge clock);
      check("pull down", 16'h000F, {8'h00, port_a_oe_b});
      rdc("port out", 9'h006, SUP, 16'h0F3C);
      acc(9'h008, 1'b0, SUP, 16'h0000);
      ext_a <= 8'h96;
      repeat (3) @(posedge clock);
      rdc("port in", 9'h006, SUP, 16'h963C);
      $display("test ports done");
      conclude();
   end
endmodule
`default_nettype wire
